// File: verilog/fair_regs_pkg.sv
// package: offsets, reset values and field layouts of the init/fairness bank
package fair_regs_pkg;
    localparam logic [7:0]  OFS_INIT_HIGH   = 8'hb4;        // init mask high
    localparam logic [7:0]  OFS_INIT_LOW    = 8'hb8;        // init mask low
    localparam logic [7:0]  OFS_FAIRNESS    = 8'hdc;        // fairness control
    localparam logic [31:0] RST_INIT_MASK   = 32'hffff_ffff; // all free
    localparam logic [31:0] RST_FAIRNESS    = 32'h0000_0000; // limit zero
    localparam int          PRI_REQ_LSB     = 0;            // limit field low bit
    localparam int          PRI_REQ_W       = 8;            // limit field width

    // register access request from host software
    typedef struct packed {
        logic        wr;                                    // write strobe
        logic        rd;                                    // read strobe
        logic [7:0]  addr;                                  // byte offset
        logic [31:0] wdata;                                 // write data
    } reg_req_t;
endpackage : fair_regs_pkg

// File: verilog/pri_req_limiter.sv
// module: counts priority arbitration requests per fairness interval
`timescale 1ns/1ps
module pri_req_limiter #(
    parameter int W = 8                                     // counter width
) (
    input  wire logic         i_mclk,                       // clock
    input  wire logic         i_rst,                        // sync reset
    input  wire logic [W-1:0] i_limit,                      // programmed limit
    input  wire logic         i_interval_start,             // interval begins
    input  wire logic         i_pri_grant,                  // request made
    output logic              o_pri_allowed                 // may use priority
);
    logic [W-1:0] used;                                     // requests so far

    // count clears at interval start; a request in that cycle counts first
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            used <= '0;
        else if (i_interval_start)
            used <= i_pri_grant ? W'(1) : '0;               // [RULE_08]
        else if (i_pri_grant && used < i_limit)
            used <= used + W'(1);                           // [RULE_05]
        // a limit lowered below the count freezes it, so it never wraps
    end

    // registered permission, recomputed every cycle
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_pri_allowed <= 1'b0;
        else if (i_interval_start)
            o_pri_allowed <= (i_limit > W'(i_pri_grant));   // [RULE_08]
        else if (i_pri_grant && used < i_limit)
            o_pri_allowed <= (used + W'(1)) < i_limit;      // [RULE_05]
        else
            o_pri_allowed <= used < i_limit;                // [RULE_05]
    end

    // once the count has reached the limit no further priority is granted
    a_cap_held : assert property (@(posedge i_mclk) // [RULE_05]
        disable iff (i_rst)
        !i_interval_start && used >= i_limit |=> !o_pri_allowed)
        else $error("priority allowed beyond limit");
    // the count stops growing at the limit
    a_count_frozen : assert property (@(posedge i_mclk) // [RULE_05]
        disable iff (i_rst)
        !i_interval_start && used >= i_limit |=> $stable(used))
        else $error("count grew past limit");
    // below the limit an idle cycle keeps priority permitted
    a_allowed_below : assert property (@(posedge i_mclk) // [RULE_07]
        disable iff (i_rst)
        !i_interval_start && !i_pri_grant && used < i_limit
        |=> o_pri_allowed)
        else $error("priority refused below limit");
    // a quiet interval start empties the count
    a_interval_clear : assert property (@(posedge i_mclk) // [RULE_08]
        disable iff (i_rst)
        i_interval_start && !i_pri_grant |=> used == '0)
        else $error("count not cleared at interval");
endmodule : pri_req_limiter

// File: verilog/bus_mgmt_init_regs.sv
// module: initial channel masks and fairness control register bank
`timescale 1ns/1ps
// Function
// RULE_01: hard or soft reset sets masks ones
// RULE_02: serial-bus reset keeps both masks unchanged
// RULE_03: resets copy upper mask into CSR
// RULE_04: resets copy lower mask into CSR
// RULE_05: priority requests never exceed programmed limit
// RULE_06: fairness upper bits read as zero
// RULE_07: software programs limit for multiple requests
// RULE_08: count clears per interval, then fair only
module bus_mgmt_init_regs (
    input  wire logic                    i_mclk,            // 50 MHz clock
    input  wire logic                    i_rst,             // hardware reset
    input  wire logic                    i_soft_rst,        // software reset
    input  wire logic                    i_global_rst,      // global reset
    input  wire logic                    i_host_bus_rst,    // host-bus reset
    input  wire logic                    i_serial_bus_rst,  // serial-bus reset
    input  wire fair_regs_pkg::reg_req_t i_req,             // register access
    input  wire logic                    i_interval_start,  // interval begins
    input  wire logic                    i_pri_grant,       // priority granted
    output logic [31:0]                  o_rdata,           // read data
    output logic                         o_rvalid,          // read data valid
    output logic [31:0]                  o_chan_avail_hi,   // CSR hi
    output logic [31:0]                  o_chan_avail_lo,   // CSR lo
    output logic                         o_pri_allowed      // priority allowed
);
    logic [31:0] initial_channel_mask_upper;                // init mask high
    logic [31:0] initial_channel_mask_lower;                // init mask low
    logic [7:0]  pri_req_limit;                             // fairness limit
    logic        init_rst;                                  // hard or soft
    logic        csr_load;                                  // any bus-side reset

    // either reset source rebuilds the masks; bus resets only copy them,
    // so a bus reset storm cannot wipe what software programmed
    assign init_rst = i_rst || i_soft_rst;
    assign csr_load = i_global_rst || i_host_bus_rst || i_serial_bus_rst;

    // upper mask: only hard/soft reset reinitialises, bus reset does not
    always_ff @(posedge i_mclk)
    begin
        if (init_rst)
            initial_channel_mask_upper <=
                fair_regs_pkg::RST_INIT_MASK;               // [RULE_01]
        else if (i_req.wr && i_req.addr == fair_regs_pkg::OFS_INIT_HIGH)
            initial_channel_mask_upper <= i_req.wdata;      // [RULE_02]
    end

    // lower mask, same policy
    always_ff @(posedge i_mclk)
    begin
        if (init_rst)
            initial_channel_mask_lower <=
                fair_regs_pkg::RST_INIT_MASK;               // [RULE_01]
        else if (i_req.wr && i_req.addr == fair_regs_pkg::OFS_INIT_LOW)
            initial_channel_mask_lower <= i_req.wdata;      // [RULE_02]
    end

    // fairness limit: only low field is stored, upper write bits dropped
    always_ff @(posedge i_mclk)
    begin
        if (init_rst)
            pri_req_limit <= fair_regs_pkg::RST_FAIRNESS[7:0];
        else if (i_req.wr && i_req.addr == fair_regs_pkg::OFS_FAIRNESS)
            pri_req_limit <= i_req.wdata[fair_regs_pkg::PRI_REQ_LSB +:
                fair_regs_pkg::PRI_REQ_W];                  // [RULE_07]
    end

    // csr copies; hard reset also loads since masks come up all ones
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_chan_avail_hi <= fair_regs_pkg::RST_INIT_MASK;
            o_chan_avail_lo <= fair_regs_pkg::RST_INIT_MASK;
        end
        // global, host-bus or serial-bus reset refreshes both copies
        else if (csr_load)
        begin
            o_chan_avail_hi <= initial_channel_mask_upper;  // [RULE_03]
            o_chan_avail_lo <= initial_channel_mask_lower;  // [RULE_04]
        end
    end

    // read port: one cycle latency, unmapped reads give zero
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_rdata  <= '0;
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rvalid <= i_req.rd;
            // strobe decoded against the three mapped offsets
            if (!i_req.rd)
                o_rdata <= '0;
            else if (i_req.addr == fair_regs_pkg::OFS_INIT_HIGH)
                o_rdata <= initial_channel_mask_upper;
            else if (i_req.addr == fair_regs_pkg::OFS_INIT_LOW)
                o_rdata <= initial_channel_mask_lower;
            else if (i_req.addr == fair_regs_pkg::OFS_FAIRNESS)
                o_rdata <= {24'h00_0000, pri_req_limit};    // [RULE_06]
            else
                o_rdata <= '0;
        end
    end

    // limiter keeps its own counter; permission output is registered there
    pri_req_limiter #(
        .W                (fair_regs_pkg::PRI_REQ_W)
    ) u_limiter (
        .i_mclk           (i_mclk),
        .i_rst            (init_rst),
        .i_limit          (pri_req_limit),
        .i_interval_start (i_interval_start),
        .i_pri_grant      (i_pri_grant),
        .o_pri_allowed    (o_pri_allowed)
    );

    // checks below end their label line with the rule they guard

    // either reset source that rebuilds the masks, one cycle long
    sequence s_mask_init;
        init_rst;
    endsequence

    // any of the three bus-side resets that refresh the csr pair
    sequence s_bus_load;
        csr_load;
    endsequence

    // first step of a fairness read: the strobe at its offset
    sequence s_fair_read;
        i_req.rd && i_req.addr == fair_regs_pkg::OFS_FAIRNESS;
    endsequence

    // second step: registered answer with the reserved bits clear
    sequence s_fair_answer;
        o_rvalid && o_rdata[31:8] == 24'h00_0000;
    endsequence

    // hard or soft reset brings both masks back to all ones
    a_soft_reset_ones : assert property (@(posedge i_mclk) // [RULE_01]
        s_mask_init |=>
        initial_channel_mask_upper == fair_regs_pkg::RST_INIT_MASK &&
        initial_channel_mask_lower == fair_regs_pkg::RST_INIT_MASK)
        else $error("masks not all ones after reset");

    // hardware reset also seeds the csr pair, matching the fresh masks
    a_hard_reset_ones : assert property (@(posedge i_mclk) // [RULE_01]
        i_rst |=>
        o_chan_avail_hi == fair_regs_pkg::RST_INIT_MASK &&
        o_chan_avail_lo == fair_regs_pkg::RST_INIT_MASK)
        else $error("csr pair not all ones after reset");

    // a serial-bus reset by itself must not touch either mask
    a_bus_rst_keeps : assert property (@(posedge i_mclk) // [RULE_02]
        disable iff (init_rst)
        i_serial_bus_rst && !i_req.wr |=>
        $stable(initial_channel_mask_upper) &&
        $stable(initial_channel_mask_lower))
        else $error("bus reset changed masks");

    // global and host-bus resets only load the copies, masks stay
    a_link_rst_keeps : assert property (@(posedge i_mclk) // [RULE_02]
        disable iff (init_rst)
        (i_global_rst || i_host_bus_rst) && !i_req.wr |=>
        $stable(initial_channel_mask_upper) &&
        $stable(initial_channel_mask_lower))
        else $error("global or host reset changed masks");

    // every load event copies the upper mask as it stood
    a_copy_high : assert property (@(posedge i_mclk) // [RULE_03]
        disable iff (i_rst)
        s_bus_load |=> o_chan_avail_hi == $past(initial_channel_mask_upper))
        else $error("hi csr not loaded");

    // every load event copies the lower mask as it stood
    a_copy_low : assert property (@(posedge i_mclk) // [RULE_04]
        disable iff (i_rst)
        s_bus_load |=> o_chan_avail_lo == $past(initial_channel_mask_lower))
        else $error("lo csr not loaded");

    // between load events the upper copy must hold still
    a_csr_hold : assert property (@(posedge i_mclk) // [RULE_03]
        disable iff (i_rst)
        !csr_load |=> $stable(o_chan_avail_hi))
        else $error("hi csr changed without load");

    // between load events the lower copy must hold still
    a_csr_hold_low : assert property (@(posedge i_mclk) // [RULE_04]
        disable iff (i_rst)
        !csr_load |=> $stable(o_chan_avail_lo))
        else $error("lo csr changed without load");

    // reserved fairness bits read back as zero whatever was written
    a_fair_reserved : assert property (@(posedge i_mclk) // [RULE_06]
        disable iff (i_rst)
        s_fair_read |=> s_fair_answer)
        else $error("fairness reserved bits nonzero");

    // the limit field itself reads back in the low byte
    a_fair_readback : assert property (@(posedge i_mclk) // [RULE_07]
        disable iff (i_rst)
        s_fair_read |=> o_rdata[7:0] == $past(pri_req_limit))
        else $error("fairness limit not read back");

    // a fairness write lands in the limit on the next edge
    a_limit_write : assert property (@(posedge i_mclk) // [RULE_07]
        disable iff (init_rst)
        i_req.wr && i_req.addr == fair_regs_pkg::OFS_FAIRNESS
        |=> pri_req_limit == $past(i_req.wdata[7:0]))
        else $error("limit not written");

    // a zero limit leaves the link with fair arbitration only
    a_zero_limit : assert property (@(posedge i_mclk) // [RULE_05]
        disable iff (init_rst)
        pri_req_limit == 8'h00 |=> !o_pri_allowed)
        else $error("priority allowed with zero limit");

    // straight after either reset no priority request is permitted
    a_reset_no_priority : assert property (@(posedge i_mclk) // [RULE_05]
        s_mask_init |=> !o_pri_allowed)
        else $error("priority allowed after reset");
endmodule : bus_mgmt_init_regs

// File: bench/bus_mgmt_init_regs_tb_top.sv
// testbench: register reads, writes, reset copies and priority limiter
`timescale 1ns/1ps
module bus_mgmt_init_regs_tb_top;
    logic                    i_mclk = 1'b0;   // 50 MHz clock
    logic                    i_rst  = 1'b1;   // hardware reset
    logic [3:0]              brst   = '0;     // soft, global, host, serial
    logic                    ivs    = 1'b0;   // interval start pulse
    logic                    grant  = 1'b0;   // priority grant pulse
    fair_regs_pkg::reg_req_t req    = '0;     // register request
    logic [31:0]             rdata;           // read data seen
    logic [31:0]             hi;              // csr copy, upper
    logic [31:0]             lo;              // csr copy, lower
    logic                    rvalid;          // read valid seen
    logic                    allowed;         // priority permission
    int                      num_errors   = 0; // mismatches
    int                      total_checks = 0; // comparisons
    int                      cycles       = 0; // hang guard
    logic [31:0]             h;               // expected upper mask
    logic [31:0]             l;               // expected lower mask

    always #10 i_mclk = ~i_mclk;

    bus_mgmt_init_regs uut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_soft_rst(brst[3]),
        .i_global_rst(brst[2]), .i_host_bus_rst(brst[1]),
        .i_serial_bus_rst(brst[0]), .i_req(req), .i_interval_start(ivs),
        .i_pri_grant(grant), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_chan_avail_hi(hi), .o_chan_avail_lo(lo), .o_pri_allowed(allowed)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // requests launch at a falling edge and drop one cycle later
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge i_mclk);
        req = '{1'b1, 1'b0, a, d};
        @(negedge i_mclk);
        req = '0;
    endtask : wr

    // read answer stands for exactly the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge i_mclk);
        req = '{1'b0, 1'b1, a, 32'h0000_0000};
        @(negedge i_mclk);
        req = '0;
        check({31'h0000_0000, rvalid}, 32'h0000_0001);
        check(rdata, exp);
    endtask : rd

    // pulses held through one rising edge, dropped at the next falling one
    task automatic step(input logic [3:0] r, input logic s, input logic g);
        @(negedge i_mclk);
        brst  = r;
        ivs   = s;
        grant = g;
        @(negedge i_mclk);
        brst  = '0;
        ivs   = 1'b0;
        grant = 1'b0;
    endtask : step

    task automatic stop_test;
        $display("errors=%0d checks=%0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    // guard against a hang; the whole run needs well under 400 cycles
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            stop_test();
        end
    end

    initial
    begin
        repeat (10) @(negedge i_mclk);
        i_rst = 1'b0;
        rd(8'hb4, 32'hffff_ffff);
        rd(8'hb8, 32'hffff_ffff);
        rd(8'hdc, 32'h0000_0000);
        check(hi & lo, 32'hffff_ffff);
        wr(8'hc0, 32'h5a5a_5a5a);
        rd(8'hc0, 32'h0000_0000);
        // each bus reset kind copies fresh masks into the csr pair
        for (int i = 0; i < 3; i++)
        begin
            h = 32'h1234_5678 ^ (32'h0101_0101 << i);
            l = 32'h9abc_def0 ^ (32'h1010_1010 << i);
            wr(8'hb4, h);
            wr(8'hb8, l);
            step(4'b0001 << i, 1'b0, 1'b0);
            step(4'b0000, 1'b0, 1'b0);
            check(hi, h);
            check(lo, l);
            rd(8'hb4, h);
            rd(8'hb8, l);
        end
        // limit of two with junk in the reserved bits
        wr(8'hdc, 32'habcd_ef02);
        rd(8'hdc, 32'h0000_0002);
        step(4'b0000, 1'b1, 1'b0);
        check(allowed, 1'b1);
        step(4'b0000, 1'b0, 1'b1);
        check(allowed, 1'b1);
        step(4'b0000, 1'b0, 1'b1);
        check(allowed, 1'b0);
        step(4'b0000, 1'b0, 1'b0);
        check(allowed, 1'b0);
        step(4'b0000, 1'b1, 1'b1);
        check(allowed, 1'b1);
        wr(8'hdc, 32'h0000_0000);
        step(4'b0000, 1'b1, 1'b0);
        check(allowed, 1'b0);
        // software reset restores masks and clears the limit
        wr(8'hdc, 32'h0000_00ff);
        step(4'b1000, 1'b0, 1'b0);
        step(4'b0000, 1'b0, 1'b0);
        rd(8'hb4, 32'hffff_ffff);
        rd(8'hb8, 32'hffff_ffff);
        rd(8'hdc, 32'h0000_0000);
        check(hi, h);
        check(lo, l);
        // hardware reset in mid-run seeds masks and copies again
        wr(8'hb4, 32'h0f0f_0f0f);
        @(negedge i_mclk);
        i_rst = 1'b1;
        @(negedge i_mclk);
        i_rst = 1'b0;
        check(hi & lo, 32'hffff_ffff);
        check(allowed, 1'b0);
        rd(8'hb4, 32'hffff_ffff);
        stop_test();
    end
endmodule : bus_mgmt_init_regs_tb_top
